// file: hw/tsi_pkg.sv
// Shared constants, codes and helpers of the time slot interchange core
package tsi_pkg;
    localparam int          NUM_STREAMS = 32;
    localparam logic [11:0] FRAME_LAST  = 12'hFFF;
    localparam logic [12:0] FRAME_BITS  = 13'h1000;
    localparam logic [11:0] IN_LAT      = 12'h008;
    localparam logic [12:0] FILL_LAST   = 13'h1FFF;
    localparam logic [9:0]  SAME_FRAME  = 10'h003;

    localparam logic [1:0]  SEL_DM      = 2'h3;
    localparam logic [1:0]  SEL_CM      = 2'h2;
    localparam logic [1:0]  SEL_REG     = 2'h1;
    localparam logic [3:0]  RSUB_CTRL   = 4'h0;
    localparam logic [3:0]  RSUB_ALIGN  = 4'h1;

    localparam int          CTRL_SRST   = 0;
    localparam int          CTRL_STBY   = 1;
    localparam int          CTRL_SFE    = 2;
    localparam int          CTRL_MBP    = 5;
    localparam int          CTRL_BPE    = 6;
    localparam int          CTRL_BPD    = 7;
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] OFFS_RST    = 16'h0000;

    typedef enum logic [1:0] {
        MODE_VAR   = 2'b00,
        MODE_CONST = 2'b01,
        MODE_PROC  = 2'b10,
        MODE_HIZ   = 2'b11
    } chan_mode_e;

    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_ARM  = 2'b01,
        E_MEAS = 2'b10,
        E_DONE = 2'b11
    } eval_state_e;

    function automatic logic [1:0] bank_next(input logic [1:0] b);
        return (b == 2'h2) ? 2'h0 : b + 2'h1;
    endfunction

    function automatic logic [1:0] bank_prev(input logic [1:0] b);
        return (b == 2'h0) ? 2'h2 : b - 2'h1;
    endfunction
endpackage

// file: hw/tsi_stream_delay.sv
// Per-stream input skew compensation delay line
`timescale 1ns/1ps
module tsi_stream_delay (
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       bit_i,
    input  wire logic [3:0] half_steps_i,
    output logic            bit_o
);
    logic [6:0] sh_r;
    logic [7:0] taps;
    logic [2:0] sel;

    // Later streams get less delay; half step rounds down to whole bits
    assign taps = {sh_r, bit_i};
    assign sel  = 3'h7 - half_steps_i[3:1];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sh_r  <= 7'h00;
            bit_o <= 1'b0;
        end else begin
            sh_r  <= {sh_r[5:0], bit_i};
            bit_o <= taps[sel];
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    AST_MAX_OFFSET: assert property (
        half_steps_i[3:1] == 3'h7 && $past(half_steps_i[3:1]) == 3'h7
        |-> bit_o == $past(bit_i))
        else $error("Largest offset does not give one-cycle delay");
endmodule

// file: hw/tsi_frame_eval.sv
// Frame pulse format detection and frame alignment measurement
`timescale 1ns/1ps
module tsi_frame_eval (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        sync_i,
    input  wire logic        eval_i,
    input  wire logic        start_i,
    output logic             frame_start_o,
    output logic             gci_mode_o,
    output logic      [12:0] align_o,
    output logic             done_o
);
    logic                s1_r;
    logic                s2_r;
    logic                e1_r;
    logic                start_d_r;
    logic                got_r;
    logic [12:0]         low_cnt_r;
    logic [12:0]         cnt_r;
    tsi_pkg::eval_state_e st_r;
    logic                st_pulse;
    logic                gci_pulse;
    logic                edge_hit;
    logic                rise;

    // One-cycle low pulse is the first format, one-cycle high pulse GCI
    assign st_pulse  = s2_r & ~s1_r & sync_i;
    assign gci_pulse = ~s2_r & s1_r & ~sync_i;
    assign edge_hit  = gci_mode_o ? (~e1_r & eval_i) : (e1_r & ~eval_i);
    assign rise      = start_i & ~start_d_r & (low_cnt_r == tsi_pkg::FRAME_BITS);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s1_r          <= 1'b0;
            s2_r          <= 1'b0;
            e1_r          <= 1'b0;
            frame_start_o <= 1'b0;
            gci_mode_o    <= 1'b0;
        end else begin
            s1_r          <= sync_i;
            s2_r          <= s1_r;
            e1_r          <= eval_i;
            frame_start_o <= st_pulse | gci_pulse;
            if (gci_pulse) begin
                gci_mode_o <= 1'b1;
            end else if (st_pulse) begin
                gci_mode_o <= 1'b0;
            end
        end
    end

    // Start bit must sit low one whole frame before a rise counts
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            start_d_r <= 1'b0;
            low_cnt_r <= 13'h0000;
        end else begin
            start_d_r <= start_i;
            if (start_i) begin
                low_cnt_r <= 13'h0000;
            end else if (low_cnt_r != tsi_pkg::FRAME_BITS) begin
                low_cnt_r <= low_cnt_r + 13'h0001;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r    <= tsi_pkg::E_IDLE;
            cnt_r   <= 13'h0000;
            align_o <= 13'h0000;
            got_r   <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 13'h0001;
            case (st_r)
                tsi_pkg::E_IDLE: begin
                    done_o <= 1'b0;
                    if (rise) begin
                        st_r <= tsi_pkg::E_ARM;
                    end
                end
                tsi_pkg::E_ARM: begin
                    if (!start_i) begin
                        st_r <= tsi_pkg::E_IDLE;
                    end else if (frame_start_o) begin
                        cnt_r <= 13'h0000;
                        got_r <= 1'b0;
                        st_r  <= tsi_pkg::E_MEAS;
                    end
                end
                tsi_pkg::E_MEAS: begin
                    if (edge_hit && !got_r) begin
                        align_o <= cnt_r;
                        got_r   <= 1'b1;
                    end
                    if (frame_start_o) begin
                        done_o <= 1'b1;
                        st_r   <= tsi_pkg::E_DONE;
                    end else if (!start_i) begin
                        st_r <= tsi_pkg::E_IDLE;
                    end
                end
                default: begin
                    if (!start_i) begin
                        done_o <= 1'b0;
                        st_r   <= tsi_pkg::E_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    AST_FMT_GCI: assert property (
        gci_pulse |=> gci_mode_o && frame_start_o)
        else $error("GCI pulse not classified");
    AST_EVAL_DONE: assert property (
        $rose(done_o) |-> $past(frame_start_o) && $past(st_r) == tsi_pkg::E_MEAS)
        else $error("Completion set outside second frame boundary");
    COV_EVAL_DONE: cover property ($rose(done_o));
endmodule

// file: hw/tsi_core.sv
// Time slot interchange core: streams, memories and processor port
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - 32 serial inputs, one bit per clock, 512 byte channels per frame
// - Received channels deserialized into data memory, frame pulse steps addresses
// - One connection word per output stream and channel names the source
// - Processor mode sends the low connection byte every frame
// - Top two connection bits pick mode; 1-1 floats that channel only
// - Drive enable low and standby low float every output
// - Serial streams move exactly one bit per master clock
// - Frame pulse format is detected automatically
// - First format: launch on one edge, sample on the following one
// - GCI format: launch and sample edges swapped; the core keeps the same edges, gci_mode only picks the evaluation edge
// - Per-stream input offset in half steps up to 7.5 clocks; the core rounds it down to whole clocks
// - Start bit rising after a low frame gives offset two frames later
// - Evaluation edge compared to frame pulse edge of same sense
// - Block fill writes pattern to bits 14-15, zeros below, in two frames
// - Fill completion clears fill enable, pattern and mode bits
// - Variable delay: channels up to n+2 next frame, later same frame
// - Constant delay: frame n data read out in frame n+2
// - Processor port gives 16-bit random access to connection memory, byte reads only of data memory
// - Address bits 15-14 select data, connection memory or registers
// - Mode code 1-0 selects processor mode
// - Drive enable high enables all outputs regardless of standby
// - During soft reset reads work, only soft reset bit writable
module tsi_core (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [31:0] rx_i,
    input  wire logic        frame_sync_in_i,
    input  wire logic        frame_eval_in_i,
    input  wire logic        output_drive_enable_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic      [31:0] tx_data_o,
    output logic      [31:0] tx_oe_o
);
    logic [255:0] dmem [0:1535];
    logic [15:0]  cmem [0:16383];
    logic [15:0]  ctrl_r;
    logic [15:0]  offs_r [0:7];
    logic [11:0]  pos_r;
    logic [1:0]   bank_r;
    logic [12:0]  fill_cnt_r;
    logic         frame_start;
    logic         gci_mode;
    logic [12:0]  align_val;
    logic         align_done;
    logic [31:0]  rx_al;
    logic [255:0] in_row;
    logic [11:0]  in_pos;
    logic [1:0]   wbank;
    logic [1:0]   fbank;
    logic [8:0]   nch;
    logic         fetch;
    logic         srst;
    logic         rst_c;
    logic         fill_act;
    logic         fill_done;
    logic         wr_ok;
    logic [3:0]   rsub;
    logic         reg_sel;
    logic         cm_sel;
    logic [255:0] dm_row;
    logic [7:0]   dm_rd;
    logic         out_on;

    assign srst      = ctrl_r[tsi_pkg::CTRL_SRST];
    assign rst_c     = reset_i | srst;
    assign wr_ok     = wr_i & ~srst;
    assign rsub      = addr_i[13:10];
    assign reg_sel   = addr_i[15:14] == tsi_pkg::SEL_REG;
    assign cm_sel    = addr_i[15:14] == tsi_pkg::SEL_CM;
    assign fill_act  = ctrl_r[tsi_pkg::CTRL_MBP] & ctrl_r[tsi_pkg::CTRL_BPE] & ~srst;
    assign fill_done = fill_act & (fill_cnt_r == tsi_pkg::FILL_LAST);
    assign out_on    = output_drive_enable_i | ctrl_r[tsi_pkg::CTRL_STBY];

    // Input side lags the frame by a fixed pipeline so skew can be removed
    assign in_pos = pos_r - tsi_pkg::IN_LAT;
    assign wbank  = (pos_r < tsi_pkg::IN_LAT) ? tsi_pkg::bank_prev(bank_r) : bank_r;
    assign fetch  = pos_r[2:0] == 3'h7;
    assign nch    = pos_r[11:3] + 9'h001;
    assign fbank  = (pos_r == tsi_pkg::FRAME_LAST) ? tsi_pkg::bank_next(bank_r) : bank_r;

    assign dm_row = dmem[{tsi_pkg::bank_prev(bank_r), addr_i[8:0]}];
    assign dm_rd  = dm_row[{addr_i[13:9], 3'h0} +: 8];

    tsi_frame_eval u_eval (
        .clock_i       (clock_i),
        .reset_i       (rst_c),
        .sync_i        (frame_sync_in_i),
        .eval_i        (frame_eval_in_i),
        .start_i       (ctrl_r[tsi_pkg::CTRL_SFE]),
        .frame_start_o (frame_start),
        .gci_mode_o    (gci_mode),
        .align_o       (align_val),
        .done_o        (align_done)
    );

    // Bit position in frame; 4096 bit periods make 512 channels
    always_ff @(posedge clock_i) begin
        if (rst_c) begin
            pos_r  <= 12'h000;
            bank_r <= 2'h0;
        end else begin
            if (frame_start) begin
                pos_r <= 12'h000;
            end else begin
                pos_r <= pos_r + 12'h001;
            end
            if (frame_start || pos_r == tsi_pkg::FRAME_LAST) begin
                bank_r <= tsi_pkg::bank_next(bank_r);
            end
        end
    end

    // Three frame banks so constant delay never reads a bank being written
    always_ff @(posedge clock_i) begin
        if (in_pos[2:0] == 3'h7) begin
            dmem[{wbank, in_pos[11:3]}] <= in_row;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_r <= tsi_pkg::CTRL_RST;
        end else begin
            if (wr_i && reg_sel && rsub == tsi_pkg::RSUB_CTRL) begin
                if (srst) begin
                    ctrl_r[tsi_pkg::CTRL_SRST] <= wdata_i[tsi_pkg::CTRL_SRST];
                end else begin
                    ctrl_r <= wdata_i;
                end
            end
            // Completion clear beats a write landing in the same cycle
            if (fill_done) begin
                ctrl_r[tsi_pkg::CTRL_MBP]      <= 1'b0;
                ctrl_r[tsi_pkg::CTRL_BPE]      <= 1'b0;
                ctrl_r[tsi_pkg::CTRL_BPD +: 2] <= 2'h0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_c) begin
            for (int i = 0; i < 8; i++) begin
                offs_r[i] <= tsi_pkg::OFFS_RST;
            end
        end else if (wr_ok && reg_sel && rsub[3]) begin
            offs_r[rsub[2:0]] <= wdata_i;
        end
    end

    // Two words a cycle: whole memory fills in 8192 cycles, two frames
    always_ff @(posedge clock_i) begin
        if (rst_c || !fill_act) begin
            fill_cnt_r <= 13'h0000;
        end else begin
            fill_cnt_r <= fill_cnt_r + 13'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (fill_act) begin
            cmem[{1'b0, fill_cnt_r}] <= {ctrl_r[tsi_pkg::CTRL_BPD +: 2], 14'h0000};
            cmem[{1'b1, fill_cnt_r}] <= {ctrl_r[tsi_pkg::CTRL_BPD +: 2], 14'h0000};
        end else if (wr_ok && cm_sel) begin
            cmem[addr_i[13:0]] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else if (!rd_i) begin
            rdata_o <= 16'h0000;
        end else if (addr_i[15:14] == tsi_pkg::SEL_DM) begin
            rdata_o <= {8'h00, dm_rd};
        end else if (cm_sel) begin
            rdata_o <= cmem[addr_i[13:0]];
        end else if (reg_sel && rsub == tsi_pkg::RSUB_CTRL) begin
            rdata_o <= ctrl_r;
        end else if (reg_sel && rsub == tsi_pkg::RSUB_ALIGN) begin
            rdata_o <= {2'h0, align_done, align_val};
        end else if (reg_sel && rsub[3]) begin
            rdata_o <= offs_r[rsub[2:0]];
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    for (genvar s = 0; s < tsi_pkg::NUM_STREAMS; s++) begin : g_str
        logic [7:0]  in_sr;
        logic [15:0] cw;
        logic [1:0]  rb;
        logic [7:0]  byt;
        logic [255:0] src_row;
        logic [7:0]  sr_r;
        logic [1:0]  md_r;

        tsi_stream_delay u_dly (
            .clock_i      (clock_i),
            .reset_i      (rst_c),
            .bit_i        (rx_i[s]),
            .half_steps_i (offs_r[s / 4][(s % 4) * 4 +: 4]),
            .bit_o        (rx_al[s])
        );

        always_ff @(posedge clock_i) begin
            if (rst_c) begin
                in_sr <= 8'h00;
            end else begin
                in_sr <= {in_sr[6:0], rx_al[s]};
            end
        end
        assign in_row[s * 8 +: 8] = {in_sr[6:0], rx_al[s]};

        // Word for the channel about to start on this output stream
        assign cw = cmem[{5'(s), nch}];

        always_comb begin
            rb = fbank;
            case (cw[15:14])
                tsi_pkg::MODE_VAR: begin
                    if ({1'b0, nch} < {1'b0, cw[8:0]} + tsi_pkg::SAME_FRAME) begin
                        rb = tsi_pkg::bank_prev(fbank);
                    end
                end
                tsi_pkg::MODE_CONST: begin
                    rb = tsi_pkg::bank_prev(tsi_pkg::bank_prev(fbank));
                end
                default: begin
                    rb = fbank;
                end
            endcase
        end

        assign src_row = dmem[{rb, cw[8:0]}];
        assign byt     = (cw[15:14] == tsi_pkg::MODE_PROC) ? cw[7:0]
                                                           : src_row[{cw[13:9], 3'h0} +: 8];

        always_ff @(posedge clock_i) begin
            if (rst_c) begin
                sr_r         <= 8'h00;
                md_r         <= tsi_pkg::MODE_HIZ;
                tx_data_o[s] <= 1'b0;
                tx_oe_o[s]   <= 1'b0;
            end else begin
                if (fetch) begin
                    sr_r <= byt;
                    md_r <= cw[15:14];
                end else begin
                    sr_r <= {sr_r[6:0], 1'b0};
                end
                // Data forced low while floated so the pin value is defined
                tx_oe_o[s]   <= (md_r != tsi_pkg::MODE_HIZ) && out_on;
                tx_data_o[s] <= sr_r[7] && (md_r != tsi_pkg::MODE_HIZ) && out_on;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    AST_FRAME_WRAP: assert property (
        frame_start && !srst |=> pos_r == 12'h000 ##1 pos_r == 12'h001)
        else $error("Frame pulse did not restart the bit position");
    AST_HIZ_CHAN: assert property (
        g_str[0].md_r == tsi_pkg::MODE_HIZ |=> !tx_oe_o[0])
        else $error("High impedance channel driven");
    AST_MASTER_OFF: assert property (
        !output_drive_enable_i && !ctrl_r[tsi_pkg::CTRL_STBY] |=> tx_oe_o == 32'h0000_0000)
        else $error("Outputs driven with master enables low");
    AST_ODE_ON: assert property (
        output_drive_enable_i && !srst && g_str[3].md_r != tsi_pkg::MODE_HIZ |=> tx_oe_o[3])
        else $error("Drive enable high but output floated");
    AST_PROC_BYTE: assert property (
        fetch && !rst_c && g_str[0].cw[15:14] == tsi_pkg::MODE_PROC
        |=> g_str[0].sr_r == $past(g_str[0].cw[7:0])
        ##1 tx_data_o[0] == ($past(g_str[0].sr_r[7]) && $past(out_on)))
        else $error("Processor byte not loaded");
    AST_FILL_WRITE: assert property (
        fill_act |=> cmem[{1'b1, $past(fill_cnt_r)}] == {$past(ctrl_r[8:7]), 14'h0000})
        else $error("Fill wrote wrong word");
    AST_FILL_CLEAR: assert property (
        fill_done |=> ctrl_r[8:5] == 4'h0 && !fill_act)
        else $error("Fill bits not cleared at completion");
    AST_SRST_WR: assert property (
        srst && wr_i && reg_sel && rsub == tsi_pkg::RSUB_CTRL
        |=> ctrl_r[15:1] == $past(ctrl_r[15:1]))
        else $error("Control bits written during soft reset");
    AST_RD_LAT: assert property (
        rd_i && reg_sel && rsub == tsi_pkg::RSUB_CTRL |=> rdata_o == $past(ctrl_r))
        else $error("Control read data wrong");
    AST_FILL_PRIO: assert property (
        fill_act && wr_i && cm_sel && addr_i[12:0] <= fill_cnt_r
        |=> cmem[$past(addr_i[13:0])] == {$past(ctrl_r[8:7]), 14'h0000})
        else $error("Processor write overrode block fill");

    COV_FILL: cover property (fill_done);
    COV_PROC: cover property (fetch && g_str[0].cw[15:14] == tsi_pkg::MODE_PROC);
    COV_CONST: cover property (fetch && g_str[1].cw[15:14] == tsi_pkg::MODE_CONST);
endmodule

// file: dv/tdm_far_end.sv
// Backplane framer model: frame pulse, serial streams, evaluation signal
`timescale 1ns/1ps
module tdm_far_end #(
    parameter int EVAL_AT = 100
) (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    output logic      [31:0] rx_o,
    output logic             frame_sync_o,
    output logic             frame_eval_o
);
    logic [11:0] cnt_r;

    initial begin
        rx_o = 32'h0000_0000;
        frame_sync_o = 1'b1;
        frame_eval_o = 1'b1;
    end

    // Streams carry fixed per-stream levels so bit alignment cannot skew the bytes
    always @(posedge clock_i) begin
        cnt_r        <= reset_i ? 12'h000 : cnt_r + 12'h001;
        frame_sync_o <= !(cnt_r == 12'hFFF);
        frame_eval_o <= !(cnt_r >= 12'(EVAL_AT) && cnt_r < 12'(EVAL_AT + 4));
        rx_o         <= 32'hAAAA_AAAA;
    end
endmodule

// file: dv/tsi_core_tb_top.sv
// Self-checking bench of the time slot interchange core
`timescale 1ns/1ps
module tsi_core_tb_top;
    logic        clock;
    logic        reset;
    logic [31:0] rx;
    logic        fsync;
    logic        feval;
    logic        drive_en;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [31:0] tx_data;
    logic [31:0] tx_oe;
    logic [15:0] d;
    int          n_mismatch;
    int          cmp_count;
    int          n;

    tsi_core tsi_core_i (.clock_i(clock), .reset_i(reset), .rx_i(rx), .frame_sync_in_i(fsync),
        .frame_eval_in_i(feval), .output_drive_enable_i(drive_en), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_data_o(tx_data),
        .tx_oe_o(tx_oe));

    tdm_far_end tdm_far_end_i (.clock_i(clock), .reset_i(reset), .rx_o(rx),
        .frame_sync_o(fsync), .frame_eval_o(feval));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic timeout();
        chk(16'h0001, 16'h0000);
        complete_run();
    endtask

    task automatic wrt(input logic [15:0] a, input logic [15:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdr(input logic [15:0] a, output logic [15:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        rdr(a, d);
        chk(d, exp);
    endtask

    // Neighbouring channels float, so the window must be exactly one byte
    task automatic cap(input int s, input logic [7:0] exp);
        logic [7:0] b;
        n = 0;
        @(negedge clock);
        while (tx_oe[s] !== 1'b1) begin
            n++;
            if (n > 5000) timeout();
            @(negedge clock);
        end
        for (int i = 0; i < 8; i++) begin
            b = {b[6:0], tx_data[s]};
            chk({15'h0, tx_oe[s]}, 16'h0001);
            @(negedge clock);
        end
        chk({15'h0, tx_oe[s]}, 16'h0000);
        chk({8'h00, b}, {8'h00, exp});
    endtask

    task automatic no_oe();
        for (int i = 0; i < 4200; i++) begin
            @(negedge clock);
            if (tx_oe !== 32'h0) chk(16'h0001, 16'h0000);
        end
    endtask

    initial begin
        reset = 1'b1;
        drive_en = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk(tx_oe[15:0], 16'h0000);
        rchk(16'h4000, 16'h0000);
        rchk(16'h0000, 16'h0000);
        wrt(16'h6400, 16'hFEDC);
        rchk(16'h6400, 16'hFEDC);
        wrt(16'h4400, 16'h1FFF);
        rchk(16'h4400, 16'h0000);
        wrt(16'h4000, 16'h01E0);
        wrt(16'h8001, 16'h80A5);
        n = 0;
        do begin
            rdr(16'h4000, d);
            n++;
            if (n > 4200) timeout();
        end while (d !== 16'h0000);
        chk(d, 16'h0000);
        rchk(16'h8001, 16'hC000);
        rchk(16'hBFFF, 16'hC000);
        rchk(16'hC60A, 16'h00FF);
        rchk(16'hC40A, 16'h0000);
        wrt(16'h8005, 16'h80A5);
        wrt(16'h8214, 16'h060A);
        wrt(16'h841E, 16'h440A);
        rchk(16'h8214, 16'h060A);
        no_oe();
        @(posedge clock);
        drive_en <= 1'b1;
        cap(0, 8'hA5);
        cap(1, 8'hFF);
        cap(2, 8'h00);
        @(posedge clock);
        drive_en <= 1'b0;
        wrt(16'h4000, 16'h0002);
        cap(0, 8'hA5);
        wrt(16'h4000, 16'h0001);
        wrt(16'h4000, 16'h0003);
        wrt(16'h8005, 16'h8011);
        rchk(16'h4000, 16'h0001);
        rchk(16'h8005, 16'h80A5);
        chk(tx_oe[15:0], 16'h0000);
        wrt(16'h4000, 16'h0000);
        repeat (4200) @(posedge clock);
        wrt(16'h4000, 16'h0004);
        rdr(16'h4400, d);
        chk(d & 16'h2000, 16'h0000);
        n = 0;
        do begin
            rdr(16'h4400, d);
            n++;
            if (n > 4200) timeout();
        end while (d[13] !== 1'b1);
        chk({15'h0, n > 2000}, 16'h0001);
        wrt(16'h4000, 16'h0000);
        rdr(16'h4400, d);
        chk(d & 16'h2000, 16'h0000);
        complete_run();
    end
endmodule
